// File: peiu_pkg.sv
// Shared constants for the event interrupt unit: map, fields, reset values, debounce counts
package peiu_pkg;

	// Slow debounce reference rate
	localparam int REF_HZ      = 32768;
	localparam int US_PER_S    = 1000000;

	// Debounce times in microseconds, as specified
	localparam int DB_SHORT_US  = 3900;
	localparam int DB_BUTTON_US = 31250;
	localparam int DB_OC_US     = 8000;

	// Debounce counter width and least counts in reference ticks (rounded up)
	localparam int CNT_W = 14;
	localparam logic [CNT_W-1:0] CNT_SHORT  =
		CNT_W'((DB_SHORT_US * REF_HZ + US_PER_S - 1) / US_PER_S);
	localparam logic [CNT_W-1:0] CNT_BUTTON =
		CNT_W'((DB_BUTTON_US * REF_HZ + US_PER_S - 1) / US_PER_S);
	localparam logic [CNT_W-1:0] CNT_OC     =
		CNT_W'((DB_OC_US * REF_HZ + US_PER_S - 1) / US_PER_S);

	// Event indices; indices 0 to 5 equal their group 0 bit positions
	localparam int NUM_EV       = 11;
	localparam int EV_BUTTON    = 0;
	localparam int EV_UNDERVOLT = 1;
	localparam int EV_TEMP_A    = 2;
	localparam int EV_OC_FIRST  = 6;

	// Per-event edge selection
	localparam logic [NUM_EV-1:0] EV_RISE_EN = 11'h7FD;
	localparam logic [NUM_EV-1:0] EV_FALL_EN = 11'h03F;

	// Synchroniser lane layout
	localparam int SYNC_W     = 13;
	localparam int LANE_FUSE  = 11;
	localparam int LANE_TICK  = 12;

	// Register offsets
	localparam logic [7:0] ADDR_STAT0  = 8'h05;
	localparam logic [7:0] ADDR_MASK0  = 8'h06;
	localparam logic [7:0] ADDR_SENSE0 = 8'h07;
	localparam logic [7:0] ADDR_STAT1  = 8'h08;
	localparam logic [7:0] ADDR_MASK1  = 8'h09;
	localparam logic [7:0] ADDR_SENSE1 = 8'h0A;

	// Field positions
	localparam int BIT_BUTTON      = 0;
	localparam int BIT_UNDERVOLT   = 1;
	localparam int BIT_TEMP_A      = 2;
	localparam int BIT_FUSE_SUPPLY = 7;
	localparam int BIT_BUCK_1A     = 0;
	localparam int BIT_BUCK_1B     = 1;
	localparam int BIT_BUCK_2      = 3;
	localparam int BIT_BUCK_3A     = 4;
	localparam int BIT_BUCK_3B     = 5;

	// Implemented bits and reset values
	localparam logic [7:0] STAT0_USED = 8'h3F;
	localparam logic [7:0] MASK0_USED = 8'h3F;
	localparam logic [7:0] MASK0_RST  = 8'h3F;
	localparam logic [7:0] STAT1_USED = 8'h3B;
	localparam logic [7:0] MASK1_USED = 8'h7F;
	localparam logic [7:0] MASK1_RST  = 8'h7F;
	localparam logic [7:0] STAT_RST   = 8'h00;

endpackage

// File: peiu_sync.sv
// Two-stage synchroniser for a bundle of asynchronous inputs
module peiu_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} peiu_sync_state_t;

	peiu_sync_state_t q_reg;
	peiu_sync_state_t q_next;

	// First stage feeds only the second
	always_comb begin
		q_next    = q_reg;
		q_next.s1 = async_in;
		q_next.s2 = q_reg.s1;
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q_reg <= '0;
		end else if (clk_en) begin
			q_reg <= q_next;
		end
	end

	assign sync_out = q_reg.s2;

endmodule

// File: peiu_debounce.sv
// One event debouncer counting slow reference ticks
module peiu_debounce (
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	input  wire logic                      clk_en,
	input  wire logic                      tick,
	input  wire logic                      raw,
	input  wire logic                      rise_en,
	input  wire logic                      fall_en,
	input  wire logic [peiu_pkg::CNT_W-1:0] rise_limit,
	input  wire logic [peiu_pkg::CNT_W-1:0] fall_limit,
	output logic                           evt
);

	typedef struct packed {
		logic                       primed;
		logic                       stable;
		logic [peiu_pkg::CNT_W-1:0] cnt;
		logic                       evt;
	} peiu_db_state_t;

	peiu_db_state_t             q_reg;
	peiu_db_state_t             q_next;
	logic [peiu_pkg::CNT_W-1:0] limit;
	logic [peiu_pkg::CNT_W:0]   cnt_inc;

	// Qualify a change only after it holds for the whole period
	always_comb begin
		q_next     = q_reg;
		q_next.evt = 1'b0;
		limit      = raw ? rise_limit : fall_limit;
		cnt_inc    = {1'b0, q_reg.cnt} + {{peiu_pkg::CNT_W{1'b0}}, 1'b1};
		if (tick) begin
			if (!q_reg.primed) begin
				q_next.primed = 1'b1; // Adopt level silently after reset
				q_next.stable = raw;
				q_next.cnt    = '0;
			end else if (raw == q_reg.stable) begin
				q_next.cnt = '0;
			end else if (cnt_inc >= {1'b0, limit}) begin
				q_next.stable = raw;
				q_next.cnt    = '0;
				q_next.evt    = raw ? rise_en : fall_en;
			end else begin
				q_next.cnt = cnt_inc[peiu_pkg::CNT_W-1:0];
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q_reg <= '0;
		end else if (clk_en) begin
			q_reg <= q_next;
		end
	end

	assign evt = q_reg.evt;

	a_db_restart: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && tick && q_reg.primed && raw == q_reg.stable |=> q_reg.cnt == '0)
		else $error("debounce count not restarted");

	a_db_evt_edge: assert property (
		@(posedge sys_clk) disable iff (rst)
		$rose(q_reg.evt) |-> q_reg.stable != $past(q_reg.stable) && $past(q_reg.cnt) != '0)
		else $error("event without qualified edge");

endmodule

// File: peiu_top.sv
// Event interrupt unit: debounced sources, sticky flags, masks, sense, interrupt pin
module peiu_top (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       slow_clk_ref,
	input  wire logic       power_button_pin,
	input  wire logic       vin_ok,
	input  wire logic [3:0] temp_above,
	input  wire logic [4:0] buck_oc,
	input  wire logic       fuse_supply_pin,
	input  wire logic [1:0] button_debounce_sel,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            irq_out_n
);

	typedef struct packed {
		logic [7:0] st0;
		logic [7:0] m0;
		logic [7:0] st1;
		logic [7:0] m1;
		logic       tick_prev;
		logic       irq_n;
		logic [7:0] rdata;
	} peiu_main_state_t;

	localparam peiu_main_state_t RST_STATE = '{
		st0:       peiu_pkg::STAT_RST,
		m0:        peiu_pkg::MASK0_RST,
		st1:       peiu_pkg::STAT_RST,
		m1:        peiu_pkg::MASK1_RST,
		tick_prev: 1'b0,
		irq_n:     1'b1,
		rdata:     8'h00
	};

	peiu_main_state_t                 q_reg;
	peiu_main_state_t                 q_next;
	logic [peiu_pkg::SYNC_W-1:0]      pins_s;
	logic [peiu_pkg::NUM_EV-1:0]      raw;
	logic [peiu_pkg::NUM_EV-1:0]      ev;
	logic                             tick;
	logic [7:0]                       set0;
	logic [7:0]                       set1;
	logic [7:0]                       sense0;
	logic [7:0]                       sense1;
	logic [7:0]                       clr0;
	logic [7:0]                       clr1;
	logic [7:0]                       pend;

	// All pin-side inputs pass two flip-flops
	peiu_sync #(
		.W(peiu_pkg::SYNC_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in ({slow_clk_ref, fuse_supply_pin, buck_oc, temp_above,
			vin_ok, power_button_pin}),
		.sync_out (pins_s)
	);

	// Debounce tick from rising edge of the slow reference
	assign tick = pins_s[peiu_pkg::LANE_TICK] & ~q_reg.tick_prev;
	assign raw  = pins_s[peiu_pkg::NUM_EV-1:0];

	// One debouncer per source with its own edges and periods
	generate
		for (genvar i = 0; i < peiu_pkg::NUM_EV; i++) begin : g_ev
			logic [peiu_pkg::CNT_W-1:0] rise_lim;
			logic [peiu_pkg::CNT_W-1:0] fall_base;
			logic [peiu_pkg::CNT_W-1:0] fall_lim;

			// Button 31.25 ms, overcurrent rising 8.0 ms, overcurrent falling and others 3.9 ms
			assign rise_lim = (i == peiu_pkg::EV_BUTTON) ? peiu_pkg::CNT_BUTTON :
				(i >= peiu_pkg::EV_OC_FIRST) ? peiu_pkg::CNT_OC :
				peiu_pkg::CNT_SHORT;
			assign fall_base = (i == peiu_pkg::EV_BUTTON) ? peiu_pkg::CNT_BUTTON :
				peiu_pkg::CNT_SHORT;

			// Falling edge of button and undervolt can be stretched
			assign fall_lim = (i <= peiu_pkg::EV_UNDERVOLT) ?
				(fall_base << button_debounce_sel) : fall_base;

			peiu_debounce u_db (
				.sys_clk    (sys_clk),
				.rst        (rst),
				.clk_en     (clk_en),
				.tick       (tick),
				.raw        (raw[i]),
				.rise_en    (peiu_pkg::EV_RISE_EN[i]),
				.fall_en    (peiu_pkg::EV_FALL_EN[i]),
				.rise_limit (rise_lim),
				.fall_limit (fall_lim),
				.evt        (ev[i])
			);
		end
	endgenerate

	// Event pulses placed at flag positions
	always_comb begin
		set0 = {2'b00, ev[peiu_pkg::EV_OC_FIRST-1:0]};
		set1 = 8'h00;
		set1[peiu_pkg::BIT_BUCK_1A] = ev[peiu_pkg::EV_OC_FIRST];
		set1[peiu_pkg::BIT_BUCK_1B] = ev[peiu_pkg::EV_OC_FIRST + 1];
		set1[peiu_pkg::BIT_BUCK_2]  = ev[peiu_pkg::EV_OC_FIRST + 2];
		set1[peiu_pkg::BIT_BUCK_3A] = ev[peiu_pkg::EV_OC_FIRST + 3];
		set1[peiu_pkg::BIT_BUCK_3B] = ev[peiu_pkg::EV_OC_FIRST + 4];
	end

	// Live sense levels, never latched
	always_comb begin
		sense0 = 8'h00;
		sense0[peiu_pkg::BIT_BUTTON]    = raw[peiu_pkg::EV_BUTTON];
		sense0[peiu_pkg::BIT_UNDERVOLT] = ~raw[peiu_pkg::EV_UNDERVOLT];
		sense0[peiu_pkg::BIT_TEMP_A +: 4] = raw[peiu_pkg::EV_TEMP_A +: 4];
		sense0[peiu_pkg::BIT_FUSE_SUPPLY] = pins_s[peiu_pkg::LANE_FUSE];
		sense1 = 8'h00;
		sense1[peiu_pkg::BIT_BUCK_1A] = raw[peiu_pkg::EV_OC_FIRST];
		sense1[peiu_pkg::BIT_BUCK_1B] = raw[peiu_pkg::EV_OC_FIRST + 1];
		sense1[peiu_pkg::BIT_BUCK_2]  = raw[peiu_pkg::EV_OC_FIRST + 2];
		sense1[peiu_pkg::BIT_BUCK_3A] = raw[peiu_pkg::EV_OC_FIRST + 3];
		sense1[peiu_pkg::BIT_BUCK_3B] = raw[peiu_pkg::EV_OC_FIRST + 4];
	end

	// Write-one-to-clear strobes
	assign clr0 = (reg_wr && reg_addr == peiu_pkg::ADDR_STAT0) ? reg_wdata : 8'h00;
	assign clr1 = (reg_wr && reg_addr == peiu_pkg::ADDR_STAT1) ? reg_wdata : 8'h00;

	// Next state: flags, masks, pin and read data
	always_comb begin
		q_next           = q_reg;
		q_next.tick_prev = pins_s[peiu_pkg::LANE_TICK];

		// Set wins over a simultaneous clear
		q_next.st0 = ((q_reg.st0 & ~clr0) | set0) & peiu_pkg::STAT0_USED;
		q_next.st1 = ((q_reg.st1 & ~clr1) | set1) & peiu_pkg::STAT1_USED;

		// Masks are plain read/write
		if (reg_wr && reg_addr == peiu_pkg::ADDR_MASK0) begin
			q_next.m0 = reg_wdata & peiu_pkg::MASK0_USED;
		end
		if (reg_wr && reg_addr == peiu_pkg::ADDR_MASK1) begin
			q_next.m1 = reg_wdata & peiu_pkg::MASK1_USED;
		end

		// Pin from next flags and masks, so unmasking acts at once
		pend         = (q_next.st0 & ~q_next.m0) | (q_next.st1 & ~q_next.m1);
		q_next.irq_n = ~|pend;

		// Read mux; unmapped offsets read zero
		if (reg_rd) begin
			case (reg_addr)
				peiu_pkg::ADDR_STAT0: begin
					q_next.rdata = q_reg.st0;
				end
				peiu_pkg::ADDR_MASK0: begin
					q_next.rdata = q_reg.m0;
				end
				peiu_pkg::ADDR_SENSE0: begin
					q_next.rdata = sense0;
				end
				peiu_pkg::ADDR_STAT1: begin
					q_next.rdata = q_reg.st1;
				end
				peiu_pkg::ADDR_MASK1: begin
					q_next.rdata = q_reg.m1;
				end
				peiu_pkg::ADDR_SENSE1: begin
					q_next.rdata = sense1;
				end
				default: begin
					q_next.rdata = 8'h00;
				end
			endcase
		end
	end

	// State register; reset loads all masks set
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q_reg <= RST_STATE;
		end else if (clk_en) begin
			q_reg <= q_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = q_reg.rdata;
	assign irq_out_n = q_reg.irq_n;

	// Pin always agrees with pending unmasked flags
	a_irq_pending: assert property (
		@(posedge sys_clk) disable iff (rst)
		irq_out_n == ~|((q_reg.st0 & ~q_reg.m0) | (q_reg.st1 & ~q_reg.m1)))
		else $error("interrupt pin disagrees with flags");

	// Written ones clear flags with no new event
	a_w1c_clear: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_STAT0
		|=> (q_reg.st0 & $past(reg_wdata) & ~$past(set0)) == 8'h00)
		else $error("write one did not clear flag");

	// Flags only fall after a clear write
	a_flag_sticky: assert property (
		@(posedge sys_clk) disable iff (rst)
		!(clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_STAT1)
		|=> (q_reg.st1 & $past(q_reg.st1)) == $past(q_reg.st1))
		else $error("group 1 flag dropped without clear");

	// Event in a clear cycle still sets
	a_set_wins: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && set0 != 8'h00 |=> (q_reg.st0 & $past(set0)) == $past(set0))
		else $error("event lost");

	// Unmasking a set flag drops the pin next edge
	a_unmask_irq: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_MASK0
		&& (q_reg.st0 & ~reg_wdata & peiu_pkg::MASK0_USED) != 8'h00
		|=> !irq_out_n)
		else $error("unmask did not raise interrupt");

	// Masks come out of reset all set
	a_mask_reset: assert property (
		@(posedge sys_clk) disable iff (rst)
		$fell(rst) |-> q_reg.m0 == peiu_pkg::MASK0_RST && q_reg.m1 == peiu_pkg::MASK1_RST
		&& irq_out_n)
		else $error("mask reset value wrong");

	// Unused and reserved bits stay zero
	a_reserved_zero: assert property (
		@(posedge sys_clk) disable iff (rst)
		(q_reg.st0 & ~peiu_pkg::STAT0_USED) == 8'h00
		&& (q_reg.st1 & ~peiu_pkg::STAT1_USED) == 8'h00 && !q_reg.m1[7])
		else $error("reserved bit set");

	// Sense read returns live comparator levels
	a_sense_read: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == peiu_pkg::ADDR_SENSE1
		|=> reg_rdata == $past(sense1))
		else $error("sense read mismatch");

	// Undervolt sense reads inverted comparator
	a_undervolt_sense: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == peiu_pkg::ADDR_SENSE0
		|=> reg_rdata[peiu_pkg::BIT_UNDERVOLT] == !$past(raw[peiu_pkg::EV_UNDERVOLT])
		&& reg_rdata[6] == 1'b0)
		else $error("undervolt sense wrong");

	// Masked flag still latches
	a_mask_no_gate: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && set1 != 8'h00 && q_reg.m1 == peiu_pkg::MASK1_RST
		|=> (q_reg.st1 & $past(set1)) == $past(set1))
		else $error("mask blocked status latch");

	// Group 1 written ones clear flags with no new event
	a_w1c_group1: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_STAT1
		|=> (q_reg.st1 & $past(reg_wdata) & ~$past(set1)) == 8'h00)
		else $error("group 1 write one did not clear flag");

	// Group 0 flags only fall after a clear write
	a_sticky_group0: assert property (
		@(posedge sys_clk) disable iff (rst)
		!(clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_STAT0)
		|=> (q_reg.st0 & $past(q_reg.st0)) == $past(q_reg.st0))
		else $error("group 0 flag dropped without clear");

	// Group 1 event in a clear cycle still sets
	a_set_wins_group1: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && set1 != 8'h00 |=> (q_reg.st1 & $past(set1)) == $past(set1))
		else $error("group 1 event lost");

	// Group 0 mask takes written bits, unused bits zero
	a_mask0_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_MASK0
		|=> q_reg.m0 == ($past(reg_wdata) & peiu_pkg::MASK0_USED))
		else $error("group 0 mask write wrong");

	// Group 1 mask takes written bits, bit 7 zero
	a_mask1_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_MASK1
		|=> q_reg.m1 == ($past(reg_wdata) & peiu_pkg::MASK1_USED))
		else $error("group 1 mask write wrong");

	// Status read returns latched group 0 flags
	a_status_read: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == peiu_pkg::ADDR_STAT0
		|=> reg_rdata == $past(q_reg.st0))
		else $error("status read mismatch");

	// Clearing the last unmasked flag releases the pin
	a_clear_release: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_STAT0 && set0 == 8'h00
		&& set1 == 8'h00 && (q_reg.st0 & ~reg_wdata & ~q_reg.m0) == 8'h00
		&& (q_reg.st1 & ~q_reg.m1) == 8'h00
		|=> irq_out_n)
		else $error("pin held low after last clear");

	// Group 0 sense read returns live synchronised pins
	a_sense0_live: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == peiu_pkg::ADDR_SENSE0
		|=> reg_rdata[peiu_pkg::BIT_BUTTON] == $past(raw[peiu_pkg::EV_BUTTON])
		&& reg_rdata[peiu_pkg::BIT_TEMP_A +: 4] == $past(raw[peiu_pkg::EV_TEMP_A +: 4])
		&& reg_rdata[peiu_pkg::BIT_FUSE_SUPPLY] == $past(pins_s[peiu_pkg::LANE_FUSE]))
		else $error("group 0 sense read wrong");

	// Reference tick lasts one enabled cycle
	a_tick_single: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && tick |=> !tick)
		else $error("reference tick held too long");

	// Unmasking a set group 1 flag drops the pin
	a_unmask_group1: assert property (
		@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == peiu_pkg::ADDR_MASK1
		&& (q_reg.st1 & ~reg_wdata & peiu_pkg::MASK1_USED) != 8'h00
		|=> !irq_out_n)
		else $error("group 1 unmask did not raise interrupt");

endmodule

// File: peiu_ref_osc.sv
// Stand-in for the slow debounce reference oscillator
module peiu_ref_osc #(
	parameter int HALF = 2
) (
	input  wire logic sys_clk,
	output logic      slow_clk_ref
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt;

	// Start low with the divider cleared
	initial begin
		slow_clk_ref = 1'b0;
		cnt = 0;
	end

	// Free-running square wave, sped up so debounce counts finish quickly
	always @(posedge sys_clk) begin
		if (cnt == HALF - 1) begin
			cnt <= 0;
			slow_clk_ref <= ~slow_clk_ref;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// File: peiu_top_test.sv
// Self-checking bench for the event interrupt unit
module peiu_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic       sys_clk, rst, clk_en, slow_clk_ref, power_button_pin, vin_ok;
	logic       fuse_supply_pin, reg_wr, reg_rd, rd_seen, irq_out_n;
	logic [3:0] temp_above;
	logic [4:0] buck_oc, o;
	logic [1:0] button_debounce_sel;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, oc_map, tbit;
	logic [7:0] exp_q[$];
	int         bad_count, checks, seed, b;

	peiu_ref_osc #(.HALF(2)) ref_u (
		.sys_clk      (sys_clk),
		.slow_clk_ref (slow_clk_ref)
	);

	peiu_top dut_u (
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.clk_en              (clk_en),
		.slow_clk_ref        (slow_clk_ref),
		.power_button_pin    (power_button_pin),
		.vin_ok              (vin_ok),
		.temp_above          (temp_above),
		.buck_oc             (buck_oc),
		.fuse_supply_pin     (fuse_supply_pin),
		.button_debounce_sel (button_debounce_sel),
		.reg_addr            (reg_addr),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_wdata           (reg_wdata),
		.reg_rdata           (reg_rdata),
		.irq_out_n           (irq_out_n)
	);

	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task finish_test;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One register write, held until the taking edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// One register read; the expected byte is queued for the monitor
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back(exp);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask

	// Bounded wait for the interrupt pin to fall
	task wait_low(input int max);
		int n;
		n = 0;
		while (irq_out_n !== 1'b0 && n < max) begin
			@(posedge sys_clk);
			n++;
		end
		check({7'h00, irq_out_n}, 8'h00);
	endtask

	// Read data lands one cycle after the taking edge
	always @(posedge sys_clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			check(reg_rdata, exp_q.pop_front());
		end
		rd_seen <= reg_rd & clk_en & ~rst;
	end

	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		$display("Watchdog expired at %0t", $time);
		finish_test();
	end

	initial begin
		seed = 32'h3612;
		sys_clk = 1'b0;
		rst = 1'b1;
		clk_en = 1'b1;
		power_button_pin = 1'b1;
		vin_ok = 1'b1;
		temp_above = 4'h0;
		buck_oc = 5'h00;
		fuse_supply_pin = 1'b1;
		button_debounce_sel = 2'b00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rd_seen = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (20) @(posedge sys_clk);

		// Reset values, read-only sense, unmapped offset, gated strobes
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h3F);
		rd(8'h07, 8'h81);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h7F);
		rd(8'h0A, 8'h00);
		rd(8'h0B, 8'h00);
		wr(8'h07, 8'hFF);
		rd(8'h07, 8'h81);
		wr(8'h09, 8'hFF);
		rd(8'h09, 8'h7F);
		@(posedge sys_clk) clk_en <= 1'b0;
		wr(8'h06, 8'h00);
		clk_en <= 1'b1;
		rd(8'h06, 8'h3F);
		wr(8'h06, 8'h3D);
		rd(8'h06, 8'h3D);
		$display("test done: map");

		// Undervolt: glitch restarts, then a full fall latches
		vin_ok <= 1'b0;
		repeat (300) @(posedge sys_clk);
		vin_ok <= 1'b1;
		repeat (700) @(posedge sys_clk);
		rd(8'h05, 8'h00);
		vin_ok <= 1'b0;
		wait_low(900);
		rd(8'h05, 8'h02);
		rd(8'h07, 8'h83);
		wr(8'h05, 8'h02);
		#1 check({7'h00, irq_out_n}, 8'h01);
		@(posedge sys_clk) vin_ok <= 1'b1;
		repeat (700) @(posedge sys_clk);
		rd(8'h05, 8'h00);
		$display("test done: undervolt");

		// Thermal: masked latch, unmask drops pin, both edges fire
		b = 2 + ($random(seed) & 3);
		tbit = 8'h01 << b;
		temp_above[b-2] <= 1'b1;
		repeat (700) @(posedge sys_clk);
		rd(8'h05, tbit);
		check({7'h00, irq_out_n}, 8'h01);
		wr(8'h06, 8'h3D & ~tbit);
		#1 check({7'h00, irq_out_n}, 8'h00);
		wr(8'h05, tbit);
		#1 check({7'h00, irq_out_n}, 8'h01);
		@(posedge sys_clk) temp_above <= 4'h0;
		wait_low(900);
		wr(8'h05, tbit);
		wr(8'h06, 8'h3D);
		$display("test done: thermal");

		// Overcurrent: rising edge only, partial clear
		o = 5'($random(seed)) | 5'h01;
		buck_oc <= o;
		oc_map = {2'b00, o[4:2], 1'b0, o[1:0]};
		repeat (1300) @(posedge sys_clk);
		rd(8'h08, oc_map);
		rd(8'h0A, oc_map);
		wr(8'h09, 8'h7E);
		#1 check({7'h00, irq_out_n}, 8'h00);
		wr(8'h08, 8'h01);
		#1 check({7'h00, irq_out_n}, 8'h01);
		rd(8'h08, oc_map & 8'hFE);
		buck_oc <= 5'h00;
		repeat (1300) @(posedge sys_clk);
		rd(8'h08, oc_map & 8'hFE);
		wr(8'h08, 8'h3B);
		wr(8'h09, 8'h7F);
		rd(8'h08, 8'h00);
		$display("test done: overcurrent");

		// Button: extended falling period, then rising edge
		button_debounce_sel <= 2'b01;
		power_button_pin <= 1'b0;
		fuse_supply_pin <= 1'b0;
		repeat (5000) @(posedge sys_clk);
		rd(8'h05, 8'h00);
		repeat (4000) @(posedge sys_clk);
		rd(8'h05, 8'h01);
		rd(8'h07, 8'h00);
		wr(8'h05, 8'h01);
		power_button_pin <= 1'b1;
		repeat (4600) @(posedge sys_clk);
		rd(8'h05, 8'h01);
		rd(8'h07, 8'h01);
		$display("test done: button");

		repeat (3) @(posedge sys_clk);
		finish_test();
	end
endmodule
